/* File: core/pmc_regs.vh */
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
// Register indices; byte address is four times the index
`define PMC_IDX_RAMP 8'h1a
`define PMC_IDX_TRIM 8'h1b
`define PMC_IDX_FLT 8'h1c
`define PMC_IDX_ROUTE 8'h20
`define PMC_IDX_STAT 8'h30
// Reset values
`define PMC_RAMP_RST 8'h0f
`define PMC_TRIM_RST 8'h02
`define PMC_FLT_RST 8'h02
`define PMC_ROUTE_RST 32'h0011_7772
// Field positions
`define PMC_RAMP_DIS_BIT 7
`define PMC_TRIM_DONE_BIT 6
`define PMC_TRIM_SEL_BIT 1
`define PMC_CH1_MOD_BIT 23
`define PMC_CH2_MOD_BIT 19
// Source codes
`define PMC_SRC_LEFT 3'h0
`define PMC_SRC_RIGHT 3'h1
`define PMC_SRC_ZERO 3'h6
// Timing: one ms tick at 250 MHz
`define PMC_CLK_KHZ 250000
`define PMC_MS_CYCLES (`PMC_CLK_KHZ * 1)
// Oscillator trim run length in clock cycles
`define PMC_TRIM_CYCLES 16'h0100
`endif

/* File: core/pmc_ctrl.v */
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_regs.vh"
module pmc_ctrl (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire shutdown_all_i,
    input wire power_down_pin_i,
    input wire backend_error_i,
    input wire [23:0] serial_in_left_i,
    input wire [23:0] serial_in_right_i,
    output reg [23:0] ch1_sample_o,
    output reg [23:0] ch2_sample_o,
    output reg ch1_three_level_o,
    output reg ch2_three_level_o,
    output reg ramp_active_o,
    output reg pwm_enable_o,
    output reg stage_reset_o,
    output reg osc_factory_trim_o
);
// ==========================================
// Input synchronisers
reg [2:0] s1;
reg [2:0] s2;
reg [2:0] s3;
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        s1 <= 3'h0;
        s2 <= 3'h0;
        s3 <= 3'h0;
    end else begin
        s1 <= {backend_error_i, power_down_pin_i, shutdown_all_i};
        s2 <= s1;
        s3 <= s2;
    end
end
// Edge detect waits until the pipe holds the pin level
// Avoids a false toggle when a pin is high at reset release
reg [1:0] sync_fill;
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        sync_fill <= 2'b00;
    end else if (sync_fill != 2'b11) begin
        sync_fill <= sync_fill + 2'b01;
    end
end
wire sync_ready = (sync_fill == 2'b11);
wire shut_chg = sync_ready && (s2[0] ^ s3[0]);
wire pdn_chg = sync_ready && (s2[1] ^ s3[1]);
wire bk_err = s2[2];
// ==========================================
// Registers and APB slave
reg [7:0] ramp_reg;
reg [7:0] trim_reg;
reg trim_done;
reg [7:0] flt_reg;
reg flt_locked;
reg [31:0] route_reg;
wire [9:0] idx = paddr[11:2];
wire wr = psel && penable && pwrite;
wire sel_ramp = (idx == {2'b00, `PMC_IDX_RAMP});
wire sel_trim = (idx == {2'b00, `PMC_IDX_TRIM});
wire sel_flt = (idx == {2'b00, `PMC_IDX_FLT});
wire sel_route = (idx == {2'b00, `PMC_IDX_ROUTE});
wire sel_stat = (idx == {2'b00, `PMC_IDX_STAT});
wire hit = sel_ramp || sel_trim || sel_flt || sel_route || sel_stat;
// Write strobes per register
wire wr_ramp = wr && sel_ramp;
wire wr_trim = wr && sel_trim;
wire wr_flt = wr && sel_flt && !flt_locked;
wire wr_route = wr && sel_route;
assign pready = 1'b1;
assign pslverr = psel && penable && !hit;
reg trim_start;
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        ramp_reg <= `PMC_RAMP_RST;
        trim_reg <= `PMC_TRIM_RST;
        flt_reg <= `PMC_FLT_RST;
        flt_locked <= 1'b0;
        route_reg <= `PMC_ROUTE_RST;
        trim_start <= 1'b0;
    end else begin
        trim_start <= 1'b0;
        if (wr_ramp) begin
            ramp_reg <= {pwdata[7], 2'b00, pwdata[4:0]};
        end
        if (wr_trim) begin
            trim_reg <= {6'h00, pwdata[`PMC_TRIM_SEL_BIT], 1'b0};
            trim_start <= 1'b1;
        end
        // Only the first write after reset lands
        if (wr_flt) begin
            flt_reg <= {4'h0, pwdata[3:0]};
            flt_locked <= 1'b1;
        end
        // Reserved routing bits keep their fixed pattern
        if (wr_route) begin
            route_reg <= {8'h00, pwdata[23:16], 16'h7772};
        end
    end
end
// Read words
wire [31:0] rd_ramp = {24'h00_0000, ramp_reg};
wire [31:0] rd_trim = {24'h00_0000, trim_reg[7], trim_done, trim_reg[5:0]};
wire [31:0] rd_flt = {24'h00_0000, flt_reg};
wire [31:0] rd_stat = {28'h000_0000, flt_locked, stage_reset_o, pwm_enable_o, ramp_active_o};
always @* begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
        case (idx)
            {2'b00, `PMC_IDX_RAMP}: prdata = rd_ramp;
            {2'b00, `PMC_IDX_TRIM}: prdata = rd_trim;
            {2'b00, `PMC_IDX_FLT}: prdata = rd_flt;
            {2'b00, `PMC_IDX_ROUTE}: prdata = route_reg;
            {2'b00, `PMC_IDX_STAT}: prdata = rd_stat;
            default: prdata = 32'h0000_0000;
        endcase
    end
end
// ==========================================
// Millisecond and 0.1 ms ticks
reg [17:0] ms_div;
reg ms_tick;
reg [14:0] ds_div;
reg ds_tick;
wire ms_wrap = (ms_div == `PMC_MS_CYCLES - 1);
wire ds_wrap = (ds_div == `PMC_MS_CYCLES / 10 - 1);
// Millisecond divider
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        ms_div <= 18'h0_0000;
        ms_tick <= 1'b0;
    end else begin
        ms_tick <= ms_wrap;
        ms_div <= ms_wrap ? 18'h0_0000 : ms_div + 18'h0_0001;
    end
end
// Tenth-millisecond divider
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        ds_div <= 15'h0000;
        ds_tick <= 1'b0;
    end else begin
        ds_tick <= ds_wrap;
        ds_div <= ds_wrap ? 15'h0000 : ds_div + 15'h0001;
    end
end
// ==========================================
// Oscillator trim
reg [15:0] trim_cnt;
wire trim_last = (trim_cnt == 16'h0001);
// Trim run counter
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        trim_cnt <= 16'h0000;
    end else if (trim_start) begin
        trim_cnt <= `PMC_TRIM_CYCLES;
    end else if (trim_cnt != 16'h0000) begin
        trim_cnt <= trim_cnt - 16'h0001;
    end
end
// Done flag: a new trim clears it, the last count sets it
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        trim_done <= 1'b0;
    end else if (trim_start) begin
        trim_done <= 1'b0;
    end else if (trim_last) begin
        trim_done <= 1'b1;
    end
end
// Trim source seen by the oscillator
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        osc_factory_trim_o <= 1'b0;
    end else if (trim_start) begin
        osc_factory_trim_o <= !trim_reg[`PMC_TRIM_SEL_BIT];
    end
end
// ==========================================
// Soft ramp period in 0.1 ms units
function [17:0] ramp_len;
    input [4:0] code;
    begin
        case (code)
            5'h08: ramp_len = 18'd165;
            5'h09: ramp_len = 18'd239;
            5'h0a: ramp_len = 18'd314;
            5'h0b: ramp_len = 18'd404;
            5'h0c: ramp_len = 18'd539;
            5'h0d: ramp_len = 18'd703;
            5'h0e: ramp_len = 18'd942;
            5'h0f: ramp_len = 18'd1257;
            5'h10: ramp_len = 18'd1646;
            5'h11: ramp_len = 18'd2394;
            5'h12: ramp_len = 18'd3142;
            5'h13: ramp_len = 18'd4039;
            5'h14: ramp_len = 18'd5386;
            5'h15: ramp_len = 18'd7031;
            5'h16: ramp_len = 18'd9425;
            5'h17: ramp_len = 18'd12566;
            5'h18: ramp_len = 18'd17281;
            5'h19: ramp_len = 18'd25136;
            5'h1a: ramp_len = 18'd32991;
            5'h1b: ramp_len = 18'd42417;
            5'h1c: ramp_len = 18'd56556;
            5'h1d: ramp_len = 18'd73837;
            5'h1e: ramp_len = 18'd98973;
            5'h1f: ramp_len = 18'd131964;
            default: ramp_len = 18'd0;
        endcase
    end
endfunction
reg [17:0] ramp_cnt;
wire [17:0] ramp_load = ramp_len(ramp_reg[4:0]);
wire ramp_go = (shut_chg || pdn_chg) && !ramp_reg[`PMC_RAMP_DIS_BIT];
// A new toggle restarts the ramp from its full length
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        ramp_cnt <= 18'h0_0000;
        ramp_active_o <= 1'b0;
    end else if (ramp_go) begin
        ramp_cnt <= ramp_load;
        ramp_active_o <= (ramp_load != 18'h0_0000);
    end else if (ramp_active_o && ds_tick) begin
        ramp_cnt <= ramp_cnt - 18'h0_0001;
        if (ramp_cnt == 18'h0_0001) begin
            ramp_active_o <= 1'b0;
        end
    end
end
// ==========================================
// Back-end fault recovery
localparam ST_RUN = 3'b001;
localparam ST_HALT = 3'b010;
localparam ST_WAIT = 3'b100;
reg [2:0] st;
reg [2:0] next_st;
reg [10:0] flt_cnt;
reg [10:0] flt_len;
wire flt_expired = ms_tick && (flt_cnt == 11'h001);
always @* begin
    case (flt_reg[3:0])
        4'h3: flt_len = 11'd449;
        4'h4: flt_len = 11'd598;
        4'h5: flt_len = 11'd748;
        4'h6: flt_len = 11'd898;
        4'h7: flt_len = 11'd1047;
        4'h8: flt_len = 11'd1197;
        4'h9: flt_len = 11'd1346;
        4'ha: flt_len = 11'd1496;
        4'hb: flt_len = 11'd1496;
        4'hc: flt_len = 11'd1496;
        4'hd: flt_len = 11'd1496;
        4'he: flt_len = 11'd1496;
        4'hf: flt_len = 11'd1496;
        default: flt_len = 11'd299;
    endcase
end
// Next-state logic
always @* begin
    next_st = st;
    case (st)
        ST_RUN: begin
            if (bk_err) begin
                next_st = ST_HALT;
            end
        end
        ST_HALT: begin
            next_st = ST_WAIT;
        end
        ST_WAIT: begin
            if (flt_expired) begin
                next_st = ST_RUN;
            end
        end
        default: begin
            next_st = ST_RUN;
        end
    endcase
end
// State, wait counter and power-stage controls
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        st <= ST_RUN;
        flt_cnt <= 11'h000;
        pwm_enable_o <= 1'b1;
        stage_reset_o <= 1'b0;
    end else begin
        st <= next_st;
        if (st == ST_HALT) begin
            flt_cnt <= flt_len;
        end else if (st == ST_WAIT && ms_tick) begin
            flt_cnt <= flt_cnt - 11'h001;
        end
        pwm_enable_o <= (next_st == ST_RUN);
        stage_reset_o <= (next_st != ST_RUN);
    end
end
// ==========================================
// Channel routing and modulation mode
function [23:0] pick;
    input [2:0] code;
    input [23:0] left;
    input [23:0] right;
    begin
        case (code)
            `PMC_SRC_LEFT: pick = left;
            `PMC_SRC_RIGHT: pick = right;
            default: pick = 24'h00_0000; // Zero and reserved codes
        endcase
    end
endfunction
wire [23:0] next_ch1 = pick(route_reg[22:20], serial_in_left_i, serial_in_right_i);
wire [23:0] next_ch2 = pick(route_reg[18:16], serial_in_left_i, serial_in_right_i);
always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        ch1_sample_o <= 24'h00_0000;
        ch2_sample_o <= 24'h00_0000;
        ch1_three_level_o <= 1'b0;
        ch2_three_level_o <= 1'b0;
    end else begin
        ch1_sample_o <= next_ch1;
        ch2_sample_o <= next_ch2;
        ch1_three_level_o <= route_reg[`PMC_CH1_MOD_BIT];
        ch2_three_level_o <= route_reg[`PMC_CH2_MOD_BIT];
    end
end
endmodule // pmc_ctrl
`default_nettype wire

/* File: tb/pmc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module pmc_host (
    input wire logic clk_sys_i,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        @(posedge clk_sys_i);
        while (pready !== 1'b1) @(posedge clk_sys_i);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // pmc_host
`default_nettype wire

/* File: tb/pmc_chk_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module pmc_chk (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic shutdown_all_i,
    input wire logic power_down_pin_i,
    input wire logic backend_error_i,
    input wire logic [23:0] serial_in_left_i,
    input wire logic [23:0] serial_in_right_i,
    input wire logic [23:0] ch1_sample_o,
    input wire logic [23:0] ch2_sample_o,
    input wire logic ch1_three_level_o,
    input wire logic ch2_three_level_o,
    input wire logic ramp_active_o,
    input wire logic pwm_enable_o,
    input wire logic stage_reset_o,
    input wire logic osc_factory_trim_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic [3:0] tog_age;
    logic pdn_q;
    logic sd_q;
    wire logic acc_wr = psel && penable && pwrite;
    wire logic trim_wr = acc_wr && paddr[11:2] == 10'h01b;
    wire logic rte_wr = acc_wr && paddr[11:2] == 10'h020;
    // Cycles since the last shutdown or power-down toggle
    always_ff @(posedge clk_sys_i) begin
        pdn_q <= power_down_pin_i;
        sd_q <= shutdown_all_i;
        if (!rst_n_i) begin
            tog_age <= 4'hf;
        end else if (pdn_q != power_down_pin_i || sd_q != shutdown_all_i) begin
            tog_age <= 4'h0;
        end else if (tog_age != 4'hf) begin
            tog_age <= tog_age + 4'h1;
        end
    end
    sequence s_err_held;
        backend_error_i [*3];
    endsequence
    sequence s_halted;
        stage_reset_o && !pwm_enable_o;
    endsequence
    a_trim_select: assert property (
        trim_wr |-> ##2 osc_factory_trim_o == !$past(pwdata[1], 2))
        else $error("factory trim output wrong after trim write");
    a_fault_halt: assert property (s_err_held |-> ##[0:3] s_halted)
        else $error("power stage not halted on back-end error");
    a_halt_pair: assert property (stage_reset_o |-> !pwm_enable_o)
        else $error("pwm active while stage held in reset");
    a_ramp_cause: assert property ($rose(ramp_active_o) |-> tog_age <= 4'h8)
        else $error("ramp started without a toggle");
    a_ramp_min: assert property ($rose(ramp_active_o) |-> ramp_active_o [*8])
        else $error("ramp ended too early");
    a_ch1_source: assert property (
        ch1_sample_o == $past(serial_in_left_i) || ch1_sample_o == $past(serial_in_right_i)
        || ch1_sample_o == 24'h0) else $error("channel 1 sample from no source");
    a_ch2_source: assert property (
        ch2_sample_o == $past(serial_in_left_i) || ch2_sample_o == $past(serial_in_right_i)
        || ch2_sample_o == 24'h0) else $error("channel 2 sample from no source");
    a_mod_change: assert property (
        $changed({ch1_three_level_o, ch2_three_level_o}) |-> $past(rte_wr) || $past(rte_wr, 2))
        else $error("modulation changed without routing write");
endmodule // pmc_chk
bind pmc_ctrl pmc_chk u_chk (.clk_sys_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .shutdown_all_i, .power_down_pin_i, .backend_error_i, .serial_in_left_i,
    .serial_in_right_i, .ch1_sample_o, .ch2_sample_o, .ch1_three_level_o,
    .ch2_three_level_o, .ramp_active_o, .pwm_enable_o, .stage_reset_o, .osc_factory_trim_o);
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_sys_i, rst_n_i, shutdown_all_i, power_down_pin_i, backend_error_i;
    logic [23:0] serial_in_left_i, serial_in_right_i;
    wire logic psel, penable, pwrite, pready, pslverr, ramp_active_o;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic [23:0] ch1_sample_o, ch2_sample_o;
    wire logic ch1_three_level_o, ch2_three_level_o;
    wire logic pwm_enable_o, stage_reset_o, osc_factory_trim_o;
    int err_count = 0;
    int n_checks = 0;
    logic [31:0] rd_v;
    logic er_v;
    localparam logic [11:0] A_RAMP = 12'h068, A_TRIM = 12'h06c, A_FLT = 12'h070;
    localparam logic [11:0] A_RTE = 12'h080, A_STAT = 12'h0c0;
    pmc_host host (.clk_sys_i, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
        .pwdata);
    pmc_ctrl dut (.clk_sys_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .shutdown_all_i, .power_down_pin_i, .backend_error_i,
        .serial_in_left_i, .serial_in_right_i, .ch1_sample_o, .ch2_sample_o,
        .ch1_three_level_o, .ch2_three_level_o, .ramp_active_o, .pwm_enable_o,
        .stage_reset_o, .osc_factory_trim_o);
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd_v, er_v);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, rd_v, er_v);
        chk(rd_v, e);
    endtask
    task do_reset;
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
    endtask
    function automatic logic [23:0] pick(input logic [2:0] c);
        return c == 3'h0 ? serial_in_left_i : c == 3'h1 ? serial_in_right_i : 24'h0;
    endfunction
    task t_defaults;
        rdc(A_RAMP, 32'h0000_000f);
        rdc(A_TRIM, 32'h0000_0002);
        rdc(A_FLT, 32'h0000_0002);
        rdc(A_RTE, 32'h0011_7772);
        rdc(A_STAT, 32'h0000_0002);
    endtask
    task t_unmapped;
        wr(12'h004, 32'hffff_ffff);
        chk(32'(er_v), 32'h1);
        rdc(12'h004, 32'h0);
        chk(32'(er_v), 32'h1);
    endtask
    task t_trim;
        wr(A_TRIM, 32'h0000_0000);
        rdc(A_TRIM, 32'h0000_0000);
        chk(32'(osc_factory_trim_o), 32'h1);
        repeat (300) @(posedge clk_sys_i);
        rdc(A_TRIM, 32'h0000_0040);
    endtask
    task t_route;
        logic [31:0] v [3];
        v = '{32'h0001_7772, 32'h0010_7772, 32'h00ee_7772};
        for (int i = 0; i < 3; i++) begin
            wr(A_RTE, v[i]);
            rdc(A_RTE, v[i]);
            repeat (3) @(posedge clk_sys_i);
            chk(32'(ch1_sample_o), 32'(pick(v[i][22:20])));
            chk(32'(ch2_sample_o), 32'(pick(v[i][18:16])));
            chk(32'({ch1_three_level_o, ch2_three_level_o}), 32'({v[i][23], v[i][19]}));
        end
        wr(A_RTE, 32'h0011_7772);
    endtask
    task t_ramp;
        wr(A_RAMP, 32'h0000_00ff);
        rdc(A_RAMP, 32'h0000_009f);
        shutdown_all_i <= ~shutdown_all_i;
        repeat (12) @(posedge clk_sys_i);
        chk(32'(ramp_active_o), 32'h0);
        wr(A_RAMP, 32'h0000_0007);
        power_down_pin_i <= ~power_down_pin_i;
        repeat (12) @(posedge clk_sys_i);
        chk(32'(ramp_active_o), 32'h0);
        wr(A_RAMP, 32'h0000_0008);
        power_down_pin_i <= ~power_down_pin_i;
        repeat (12) @(posedge clk_sys_i);
        chk(32'(ramp_active_o), 32'h1);
    endtask
    task t_fault;
        wr(A_FLT, 32'h0000_0005);
        wr(A_FLT, 32'h0000_0009);
        rdc(A_FLT, 32'h0000_0005);
        rdc(A_STAT, 32'h0000_000b);
        backend_error_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        backend_error_i <= 1'b0;
        repeat (1000) @(posedge clk_sys_i);
        chk(32'({pwm_enable_o, stage_reset_o}), 32'h1);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        give_verdict;
    end
    initial begin
        rst_n_i = 1'b0;
        shutdown_all_i = 1'b0;
        power_down_pin_i = 1'b0;
        backend_error_i = 1'b0;
        serial_in_left_i = 24'h13_579b;
        serial_in_right_i = 24'h24_68ac;
        do_reset;
        t_defaults;
        t_unmapped;
        t_trim;
        t_route;
        t_ramp;
        t_fault;
        do_reset;
        t_defaults;
        wr(A_FLT, 32'h0000_0003);
        rdc(A_FLT, 32'h0000_0003);
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
